// ---- verilog/pump_ctrl_defs.svh ----
`ifndef PUMP_CTRL_DEFS_SVH
`define PUMP_CTRL_DEFS_SVH

// ****************************************
// Register addresses on the transmitter register port
// ****************************************
`define TRIM_ADDR 8'h08
`define CTRL2_ADDR 8'h0a

// ****************************************
// Field positions
// ****************************************
`define TRIM_BLEED_BIT 5
`define CTRL2_RUN_BIT 0
`define CTRL2_TSEL_LO 1
`define CTRL2_TSEL_HI 2
`define CTRL2_BATT_BIT 3
`define CTRL2_CAP_BIT 4

// ****************************************
// Reset values
// ****************************************
`define TRIM_RESET 8'h00
`define CTRL2_RESET 8'h00

// ****************************************
// Timing
// ****************************************
// System clock cycles per pump oscillator period.
`define OSC_DIV 8'h0a
// Default oscillator periods in the shortest charge time.
`define TIMEOUT_BASE_TICKS 32'h00000400

`endif

// ---- verilog/pump_ctrl_pkg.sv ----
package pump_ctrl_pkg;

  // Host write and read request on the register port.
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  // Software control bits held by the block.
  typedef struct packed {
    logic [1:0] tsel;
    logic cap_sel;
    logic batt_sel;
    logic bleed;
  } ctrl_t;

  typedef enum logic {
    PUMP_IDLE,
    PUMP_CHARGING
  } pump_state_t;

endpackage

// ---- verilog/rf_charge_pump_control.sv ----
`timescale 1ns/100ps
`include "pump_ctrl_defs.svh"

module rf_charge_pump_control #(
  parameter int TIMEOUT_BASE_TICKS = `TIMEOUT_BASE_TICKS
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic rf_reset_i,
  input wire pump_ctrl_pkg::reg_req_t req_i,
  input wire logic charge_limit_i,
  output logic [7:0] rdata_o,
  output logic pump_en_o,
  output logic bleed_en_o,
  output logic cap_sel_o,
  output logic batt_sel_o
);
  import pump_ctrl_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  pump_state_t state_r, state_nxt;
  ctrl_t ctrl_r, ctrl_nxt;
  logic [7:0] div_r, div_nxt;
  logic [15:0] ticks_r, ticks_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic pump_en_r, pump_en_nxt;
  logic wr_trim, wr_ctrl2, osc_tick;
  logic timeout_hit, run_set_req, run_clr_req;

  // Charge time in oscillator periods doubles with each select step.
  function automatic logic [15:0] tick_limit(input logic [1:0] sel);
    tick_limit = 16'(TIMEOUT_BASE_TICKS) << sel;
  endfunction

  // Address match for the trim register; shared by write and read decode.
  function automatic logic is_trim(input logic [7:0] addr);
    is_trim = (addr == `TRIM_ADDR);
  endfunction

  // Address match for the second control register.
  function automatic logic is_ctrl2(input logic [7:0] addr);
    is_ctrl2 = (addr == `CTRL2_ADDR);
  endfunction

  // Readback image of the trim register. Only the bleed bit is real; the
  // reserved positions are forced low so software never sees stale bits.
  function automatic logic [7:0] trim_image(input logic bleed);
    trim_image = 8'h00;
    trim_image[`TRIM_BLEED_BIT] = bleed;
  endfunction

  // Readback image of the second control register. The run position shows
  // the live charge state rather than a stored bit, so polling sees the
  // hardware end of a cycle without any extra clearing logic.
  function automatic logic [7:0] ctrl2_image(input logic charging,
                                             input ctrl_t bits);
    ctrl2_image = 8'h00;
    ctrl2_image[`CTRL2_RUN_BIT] = charging;
    ctrl2_image[`CTRL2_TSEL_HI:`CTRL2_TSEL_LO] = bits.tsel;
    ctrl2_image[`CTRL2_BATT_BIT] = bits.batt_sel;
    ctrl2_image[`CTRL2_CAP_BIT] = bits.cap_sel;
  endfunction

  // ****************************************
  // Register port decode
  // ****************************************
  assign wr_trim = req_i.wr && is_trim(req_i.addr);
  assign wr_ctrl2 = req_i.wr && is_ctrl2(req_i.addr);
  // Run bit requests carried by a write of the second control register.
  assign run_set_req = wr_ctrl2 && req_i.wdata[`CTRL2_RUN_BIT];
  assign run_clr_req = wr_ctrl2 && !req_i.wdata[`CTRL2_RUN_BIT];
  // The oscillator only runs while charging, so no tick when idle.
  assign osc_tick = (state_r == PUMP_CHARGING) && (div_r == `OSC_DIV - 8'h01);
  // Greater-or-equal rather than equal: if the host shortens the select in
  // mid-charge the counter may already be past the new limit, and an
  // equality test would then let the pump run until the counter wraps.
  assign timeout_hit = osc_tick &&
    (ticks_r >= tick_limit(ctrl_r.tsel) - 16'h0001);

  // Control bits; the transmitter reset clears all of them.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (rf_reset_i) begin
      ctrl_nxt = '0;
    end else begin
      if (wr_trim) begin
        ctrl_nxt.bleed = req_i.wdata[`TRIM_BLEED_BIT];
      end
      if (wr_ctrl2) begin
        ctrl_nxt.tsel = req_i.wdata[`CTRL2_TSEL_HI:`CTRL2_TSEL_LO];
        ctrl_nxt.cap_sel = req_i.wdata[`CTRL2_CAP_BIT];
        ctrl_nxt.batt_sel = req_i.wdata[`CTRL2_BATT_BIT];
      end
    end
  end

  // ****************************************
  // Charge cycle control
  // ****************************************
  // A host write of the run bit takes priority over the hardware end, so a
  // restart written in the ending cycle is not lost.
  always_comb begin
    state_nxt = state_r;
    div_nxt = div_r;
    ticks_nxt = ticks_r;
    unique case (state_r)
      PUMP_IDLE: begin
        if (wr_ctrl2 && req_i.wdata[`CTRL2_RUN_BIT]) begin
          state_nxt = PUMP_CHARGING;
          div_nxt = 8'h00;
          ticks_nxt = 16'h0000;
        end
      end
      PUMP_CHARGING: begin
        div_nxt = osc_tick ? 8'h00 : div_r + 8'h01;
        ticks_nxt = osc_tick ? ticks_r + 16'h0001 : ticks_r;
        if (run_clr_req) begin
          state_nxt = PUMP_IDLE;
        end else if (charge_limit_i || timeout_hit) begin
          if (run_set_req) begin
            // The host sets run in the very cycle that hardware ends the
            // charge: the bit falls and rises again, so count afresh.
            div_nxt = 8'h00;
            ticks_nxt = 16'h0000;
          end else if (charge_limit_i) begin
            state_nxt = PUMP_IDLE;
          end else begin
            state_nxt = PUMP_IDLE;
          end
        end
      end
    endcase
    if (rf_reset_i) begin
      state_nxt = PUMP_IDLE;
      div_nxt = 8'h00;
      ticks_nxt = 16'h0000;
    end
    pump_en_nxt = (state_nxt == PUMP_CHARGING);
  end

  // ****************************************
  // Read data
  // ****************************************
  // Read data is registered, so it appears the cycle after the strobe.
  always_comb begin
    rdata_nxt = rdata_r;
    if (req_i.rd) begin
      if (is_trim(req_i.addr)) begin
        rdata_nxt = trim_image(ctrl_r.bleed);
      end else if (is_ctrl2(req_i.addr)) begin
        rdata_nxt = ctrl2_image(state_r == PUMP_CHARGING, ctrl_r);
      end else begin
        // Unmapped addresses read as zero rather than as a stale byte.
        rdata_nxt = 8'h00;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Software control bits. Only the main reset is asynchronous; the
  // transmitter reset arrives through the next-value logic above.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Charge state, oscillator divider, timeout counter and pump enable.
  // The enable is its own flop so the pin never glitches on state decode.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= PUMP_IDLE;
      div_r <= 8'h00;
      ticks_r <= 16'h0000;
      pump_en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      ticks_r <= ticks_nxt;
      pump_en_r <= pump_en_nxt;
    end
  end

  // Read data holder; it keeps the last answer until the next read strobe.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every pin is a flop output. The supply selects follow host writes
  // directly; keeping them exclusive is left to the host.
  assign rdata_o = rdata_r;
  assign pump_en_o = pump_en_r;
  assign bleed_en_o = ctrl_r.bleed;
  assign cap_sel_o = ctrl_r.cap_sel;
  assign batt_sel_o = ctrl_r.batt_sel;

endmodule // rf_charge_pump_control

// ---- verification/pump_ctrl_properties.sv ----
`timescale 1ns/100ps
// ****
// Checker
// ****
module pump_ctrl_checker (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic rf_reset_i,
  input wire pump_ctrl_pkg::reg_req_t req_i,
  input wire logic charge_limit_i,
  input wire logic [7:0] rdata_o,
  input wire logic pump_en_o,
  input wire logic bleed_en_o,
  input wire logic cap_sel_o,
  input wire logic batt_sel_o
);
  import pump_ctrl_pkg::*;
  logic w0a, w08;
  // Qualified writes; a transmitter reset in the same cycle wins.
  assign w0a = req_i.wr && req_i.addr == 8'h0a && !rf_reset_i;
  assign w08 = req_i.wr && req_i.addr == 8'h08 && !rf_reset_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  chk_run_starts: assert property (
    w0a && req_i.wdata[0] && !pump_en_o |=> pump_en_o) else $error("no start");
  chk_write_stops: assert property (
    w0a && !req_i.wdata[0] |=> !pump_en_o) else $error("no abort");
  chk_limit_stops: assert property (
    charge_limit_i && !w0a && !rf_reset_i |=> !pump_en_o) else $error("limit");
  chk_charge_bounded: assert property (
    $rose(pump_en_o) |-> ##[1:340] !pump_en_o) else $error("no timeout");
  chk_bleed_follows: assert property (
    w08 |=> bleed_en_o == $past(req_i.wdata[5])) else $error("bleed");
  chk_supply_follows: assert property (
    w0a |=> cap_sel_o == $past(req_i.wdata[4])) else $error("cap select");
  chk_reset_clears: assert property (
    rf_reset_i |=> !bleed_en_o && !pump_en_o) else $error("rf reset");
  chk_run_polls: assert property (
    req_i.rd && req_i.addr == 8'h0a && pump_en_o ##1 pump_en_o |-> rdata_o[0])
    else $error("run readback");
  cover property (w0a && req_i.wdata[0]);
  cover property (charge_limit_i && pump_en_o);
  cover property ($fell(pump_en_o));
endmodule // pump_ctrl_checker

bind rf_charge_pump_control pump_ctrl_checker chk_inst (.clock_i, .rst_i,
  .rf_reset_i, .req_i, .charge_limit_i, .rdata_o, .pump_en_o, .bleed_en_o,
  .cap_sel_o, .batt_sel_o);

// ---- verification/pump_host_model.sv ----
`timescale 1ns/100ps
// Host on the register port; the bench calls keep the host order.
// It never keys the transmitter, so the burst duty limit holds.
module pump_host_model (
  input wire logic clock_i,
  output pump_ctrl_pkg::reg_req_t req_o
);
  initial req_o = '0;
  // One request for one cycle; on release the strobes drop and address and data carry inverted junk.
  task automatic put(input logic [7:0] a, d, input logic w);
    @(posedge clock_i);
    #1;
    req_o = '{a, w, !w, d};
    @(posedge clock_i);
    #1;
    req_o = '{~a, 1'b0, 1'b0, ~d};
  endtask
endmodule // pump_host_model

// ---- verification/rf_charge_pump_control_tb_top.sv ----
`timescale 1ns/100ps
module rf_charge_pump_control_tb_top;
  import pump_ctrl_pkg::*;
  localparam int BASE = 4;
  logic clock_i = 0, rst_i = 1, rf_reset_i = 0, charge_limit_i = 0;
  reg_req_t req_i;
  logic [7:0] rdata_o;
  logic pump_en_o, bleed_en_o, cap_sel_o, batt_sel_o;
  int num_errors = 0, compares = 0, n;
  typedef struct {logic [7:0] a, d, r; logic [2:0] o;} row_t;
  // Rows: address, write data, readback, {bleed, cap, battery}.
  // Capacitor to battery passes through an all-clear row, as the host must.
  row_t rows[6] = '{'{8'h08, 8'hff, 8'h20, 3'b100},
    '{8'h0a, 8'h16, 8'h16, 3'b110}, '{8'h08, 8'hdf, 8'h00, 3'b010},
    '{8'h0a, 8'h00, 8'h00, 3'b000}, '{8'h0a, 8'h08, 8'h08, 3'b001},
    '{8'h0c, 8'hff, 8'h00, 3'b001}};
  rf_charge_pump_control #(.TIMEOUT_BASE_TICKS(BASE))
    rf_charge_pump_control_inst (.clock_i, .rst_i, .rf_reset_i, .req_i,
    .charge_limit_i, .rdata_o, .pump_en_o, .bleed_en_o, .cap_sel_o,
    .batt_sel_o);
  pump_host_model pump_host_model_inst (.clock_i, .req_o(req_i));
  initial forever #5 clock_i = ~clock_i;
  task automatic cmp(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    pump_host_model_inst.put(a, d, 1'b1);
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog well beyond the longest charge.
  initial begin
    #300000;
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    #1 rst_i = 0;
    cmp({4'h0, bleed_en_o, cap_sel_o, batt_sel_o, pump_en_o}, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      pump_host_model_inst.put(rows[i].a, 8'h00, 1'b0);
      cmp(rdata_o, rows[i].r);
      cmp({5'h0, bleed_en_o, cap_sel_o, batt_sel_o},
        {5'h0, rows[i].o});
    end
    // Clear all, start a short charge, see it run, then stop it by write.
    wr(8'h0a, 8'h00);
    wr(8'h0a, 8'h01);
    repeat (25) @(posedge clock_i);
    #1;
    cmp({7'h0, pump_en_o}, 8'h01);
    wr(8'h0a, 8'h00);
    cmp({7'h0, pump_en_o}, 8'h00);
    // Each select in turn; a stale counter would shorten the first.
    for (int k = 0; k < 4; k++) begin
      wr(8'h0a, {5'h0, k[1:0], 1'b1});
      n = 0;
      while (pump_en_o === 1'b1 && n < 2000) begin
        @(posedge clock_i);
        #1;
        n++;
      end
      cmp({7'h0, n == (BASE << k) * 10}, 8'h01);
    end
    // Polling after the timeout sees run low and the select kept.
    pump_host_model_inst.put(8'h0a, 8'h00, 1'b0);
    cmp(rdata_o, 8'h06);
    wr(8'h0a, 8'h01);
    pump_host_model_inst.put(8'h0a, 8'h00, 1'b0);
    cmp({7'h0, rdata_o[0]}, 8'h01);
    charge_limit_i = 1;
    @(posedge clock_i);
    #1;
    cmp({7'h0, pump_en_o}, 8'h00);
    charge_limit_i = 0;
    wr(8'h0a, 8'h10);
    wr(8'h08, 8'h20);
    cmp({6'h0, bleed_en_o, cap_sel_o}, 8'h03);
    rf_reset_i = 1;
    @(posedge clock_i);
    #1;
    rf_reset_i = 0;
    cmp({6'h0, bleed_en_o, cap_sel_o}, 8'h00);
    // Main reset in mid-charge; the first request follows at once.
    wr(8'h0a, 8'h01);
    rst_i = 1;
    @(posedge clock_i);
    #1;
    rst_i = 0;
    cmp({4'h0, bleed_en_o, cap_sel_o, batt_sel_o, pump_en_o}, 8'h00);
    pump_host_model_inst.put(8'h0a, 8'h00, 1'b0);
    cmp(rdata_o, 8'h00);
    wrap_up();
  end
endmodule // rf_charge_pump_control_tb_top
